/* File: logic/ssm_supervisor.sv */
// System supervisor: power-on gating, rail and brown-out monitoring,
// two windowed watchdogs, temperature gating, clock ratio and two serial ports.
// Assumes all pins are asynchronous to mclk_i and are synchronised here.
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1: Supply monitor reset clears all logic.
// R2: After reset, power request gates power-on.
// R3: Brown-out parks mirrors, then ready-off.
// R4: OR rail faults into aggregate power good.
// R5: Two fully independent watchdogs.
// R6: Controller toggles triggers from health signals.
// R7: Registers set window open and close.
// R8: Rising trigger edge starts watchdog cycle.
// R9: Edge before window opens is error.
// R10: Window closing without edge is error.
// R11: Every rising edge restarts the cycle.
// R12: Two temperature monitors, warn and error.
// R13: Warning may raise processor interrupt.
// R14: Over-temperature shuts down until request toggles.
// R15: Power-on waits for temperature below warning.
// R16: Temperature bits readable on both ports.
// R17: Measure and report internal/external clock ratio.
// R18: Controller compares ratio with expected value.
// R19: Two serial ports; primary reads and writes.
// R20: Secondary port reads everything, never writes.
// R21: Chip select low frames each transfer.
// R22: Secondary samples data on rising clock.
// R23: Far end always sends complete frames.
// R24: Enabled watchdog error returns to off.
// R25: Shutdown exits only on request low.
// R26: Disabled watchdog never flags errors.
// R27: Watchdog and ratio timing use internal clock.
module ssm_supervisor #(
  parameter int PARK_CYC = ssm_pkg::PARK_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Power control
  input wire logic system_power_request_i,
  input wire logic main_input_brownout_sense_i,
  input wire logic [3:0] rail_fault_i,
  input wire logic mirror_power_request_i,
  output logic rail_enable_o,
  output logic host_reset_n_o,
  output logic park_n_o,
  output logic mirror_supply_en_o,
  output logic rail_monitor_aggregate_good_o,
  output logic [2:0] state_o,
  // Watchdogs
  input wire logic [1:0] watchdog_trigger_input_i,
  output logic [1:0] watchdog_error_o,
  // Temperature
  input wire logic [1:0] temp_warn_i,
  input wire logic [1:0] temp_err_i,
  output logic temp_warn_irq_o,
  // Clock monitor
  input wire logic external_sequencer_clock_i,
  // Serial ports, index 0 primary, 1 monitor
  input wire ssm_pkg::ssm_spi_in_s [1:0] spi_i,
  output logic [1:0] spi_miso_o,
  output logic [1:0] spi_miso_oe_o
);
  import ssm_pkg::*;

  localparam int NSYNC = 20;
  // Chip selects rest high so that no frame appears during or right after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 20'h0_0012;

  // Two-flop synchronisers on every pin
  logic [NSYNC-1:0] sync1_r, sync2_r, prev_r;
  logic [NSYNC-1:0] pins;
  assign pins = {system_power_request_i, main_input_brownout_sense_i, rail_fault_i, mirror_power_request_i,
                 watchdog_trigger_input_i, temp_warn_i, temp_err_i, external_sequencer_clock_i,
                 spi_i[1], spi_i[0]};
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
      prev_r <= SYNC_IDLE;
    end
    else
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  logic s_req, s_brown, s_mreq, s_seq, seq_rise;
  logic [3:0] s_fault;
  logic [1:0] s_wd, wd_rise, s_warn, s_err;
  assign {s_req, s_brown, s_fault, s_mreq, s_wd, s_warn, s_err, s_seq} = sync2_r[19:6];
  assign wd_rise = s_wd & ~prev_r[12:11];
  assign seq_rise = s_seq & ~prev_r[6];

  // Register file
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] wd_open_r [2], wd_close_r [2], wd_open_nxt [2], wd_close_nxt [2];
  logic wr_stb [2];
  logic [6:0] wr_addr [2];
  logic [15:0] wr_data [2];
  logic [1:0] wd_en, wd_err_r, wd_err_nxt, wd_clr;
  logic sw_park, sw_cycle, pg;
  logic [15:0] ratio_r, ratio_nxt;
  ssm_state_e state_r, state_nxt;

  assign pg = ~|s_fault;  // [R4]
  assign wd_en = ctrl_r[CTRL_WD_EN_LSB +: 2];
  // Only the primary port's strobe reaches storage
  assign sw_park = wr_stb[0] && wr_addr[0] == REG_CTRL && wr_data[0][CTRL_SW_PARK];
  assign sw_cycle = wr_stb[0] && wr_addr[0] == REG_CTRL && wr_data[0][CTRL_SW_CYCLE];
  assign wd_clr = (wr_stb[0] && wr_addr[0] == REG_STATUS) ? wr_data[0][STAT_WDERR_LSB +: 2] : 2'b00;

  function automatic logic [15:0] reg_read(input logic [6:0] a);
    logic [15:0] d;
    d = 16'h0000;
    unique case (a)
      REG_STATUS:
      begin
        d[STAT_TEMP_LSB +: 4] = {s_err, s_warn};  // [R12] [R16]
        d[STAT_WDERR_LSB +: 2] = wd_err_r;
        d[STAT_PG] = pg;
        d[STAT_BROWN] = s_brown;
        d[STAT_STATE_LSB +: 3] = state_r;
      end
      REG_CTRL: d = ctrl_r;
      REG_WD1_OPEN: d = wd_open_r[0];
      REG_WD1_CLOSE: d = wd_close_r[0];
      REG_WD2_OPEN: d = wd_open_r[1];
      REG_WD2_CLOSE: d = wd_close_r[1];
      REG_RATIO: d = ratio_r;  // [R17]
      REG_REV: d = REV_ID;
      default: d = 16'h0000;
    endcase
    return d;
  endfunction

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    wd_open_nxt = wd_open_r;
    wd_close_nxt = wd_close_r;
    if (wr_stb[0])  // [R19]
    begin
      unique case (wr_addr[0])
        REG_CTRL: ctrl_nxt = wr_data[0] & ~(16'h0001 << CTRL_SW_PARK) & ~(16'h0001 << CTRL_SW_CYCLE);
        REG_WD1_OPEN: wd_open_nxt[0] = wr_data[0];  // [R7]
        REG_WD1_CLOSE: wd_close_nxt[0] = wr_data[0];
        REG_WD2_OPEN: wd_open_nxt[1] = wr_data[0];
        REG_WD2_CLOSE: wd_close_nxt[1] = wr_data[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)  // [R1]
    begin
      ctrl_r <= CTRL_RST;
      wd_open_r <= '{WD_OPEN_RST, WD_OPEN_RST};
      wd_close_r <= '{WD_CLOSE_RST, WD_CLOSE_RST};
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      wd_open_r <= wd_open_nxt;
      wd_close_r <= wd_close_nxt;
    end
  end

  // Serial ports: 8-bit command (write flag, 7-bit index), then 16 data bits, MSB first
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    logic cs_n, sclk, mosi, rise, fall, start;
    logic [4:0] cnt_r, cnt_nxt;
    logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic wr_r, wr_nxt;
    logic wf_r, wf_nxt;
    logic [15:0] wd_r, wd_nxt;
    assign {sclk, cs_n, mosi} = sync2_r[3*p +: 3];
    assign rise = sclk & ~prev_r[3*p+2];
    assign fall = ~sclk & prev_r[3*p+2];
    assign start = ~cs_n & prev_r[3*p+1];

    always_comb
    begin
      cnt_nxt = cnt_r;
      rx_nxt = rx_r;
      tx_nxt = tx_r;
      addr_nxt = addr_r;
      wr_nxt = 1'b0;
      wf_nxt = wf_r;
      wd_nxt = wd_r;
      if (start)  // [R21]
      begin
        cnt_nxt = 5'd0;
        tx_nxt = 16'h0000;
      end
      else if (!cs_n && rise)  // [R22]
      begin
        rx_nxt = {rx_r[14:0], mosi};
        if (cnt_r != 5'(FRAME_BITS))
          cnt_nxt = cnt_r + 5'd1;
        if (cnt_r == 5'(CMD_BITS - 1))
        begin
          addr_nxt = {rx_r[5:0], mosi};
          // The write flag has left the 16-bit shifter by the end of the frame
          wf_nxt = rx_r[6];
          tx_nxt = reg_read({rx_r[5:0], mosi});
        end
        // Write only on a complete frame, primary port only
        if (cnt_r == 5'(FRAME_BITS - 1) && p == 0 && wf_r)  // [R20] [R23]
        begin
          wr_nxt = 1'b1;
          wd_nxt = {rx_r[14:0], mosi};
        end
      end
      else if (!cs_n && fall && cnt_r > 5'(CMD_BITS))
        tx_nxt = {tx_r[14:0], 1'b0};
    end

    always_ff @(posedge mclk_i)
    begin
      if (reset_i)
      begin
        cnt_r <= 5'd0;
        rx_r <= 16'h0000;
        tx_r <= 16'h0000;
        addr_r <= 7'h00;
        wr_r <= 1'b0;
        wf_r <= 1'b0;
        wd_r <= 16'h0000;
      end
      else
      begin
        cnt_r <= cnt_nxt;
        rx_r <= rx_nxt;
        tx_r <= tx_nxt;
        addr_r <= addr_nxt;
        wr_r <= wr_nxt;
        wf_r <= wf_nxt;
        wd_r <= wd_nxt;
      end
    end
    assign wr_stb[p] = wr_r;
    assign wr_addr[p] = addr_r;
    assign wr_data[p] = wd_r;
    assign spi_miso_o[p] = tx_r[15];
    assign spi_miso_oe_o[p] = ~cs_n;
  end

  // Watchdog time base runs on the internal clock so a dead sequencer clock is still caught
  logic [5:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  assign tick = tick_cnt_r == 6'(WD_TICK_CYC - 1);  // [R27]
  always_comb
    tick_cnt_nxt = tick ? 6'd0 : tick_cnt_r + 6'd1;

  logic [15:0] wd_cnt_r [2], wd_cnt_nxt [2];
  logic [1:0] wd_arm_r, wd_arm_nxt;
  for (genvar w = 0; w < 2; w++)
  begin : g_wd  // [R5]
    always_comb
    begin
      wd_cnt_nxt[w] = wd_cnt_r[w];
      wd_arm_nxt[w] = wd_arm_r[w];
      wd_err_nxt[w] = wd_err_r[w] & ~wd_clr[w];
      if (!wd_en[w])  // [R26]
      begin
        wd_arm_nxt[w] = 1'b0;
        wd_err_nxt[w] = 1'b0;
      end
      else if (wd_rise[w])  // [R8] [R11]
      begin
        if (wd_arm_r[w] && wd_cnt_r[w] < wd_open_r[w])
          wd_err_nxt[w] = 1'b1;  // [R9]
        wd_cnt_nxt[w] = 16'h0000;
        wd_arm_nxt[w] = 1'b1;
      end
      else if (wd_arm_r[w] && tick)
      begin
        if (wd_cnt_r[w] >= wd_close_r[w])
        begin
          wd_err_nxt[w] = 1'b1;  // [R10]
          wd_arm_nxt[w] = 1'b0;
        end
        else
          wd_cnt_nxt[w] = wd_cnt_r[w] + 16'h0001;
      end
    end
  end

  // Clock ratio: external edges per fixed internal window; 25 MHz is the sampling limit
  logic [15:0] win_r, win_nxt, edge_r, edge_nxt;
  always_comb
  begin
    ratio_nxt = ratio_r;
    win_nxt = win_r + 16'h0001;
    edge_nxt = edge_r + {15'h0000, seq_rise};
    if (win_r == 16'(RATIO_WIN_CYC - 1))  // [R17] [R27]
    begin
      ratio_nxt = edge_nxt;
      win_nxt = 16'h0000;
      edge_nxt = 16'h0000;
    end
  end

  // System state machine
  logic [15:0] tmr_r, tmr_nxt;
  logic to_off_r, to_off_nxt, to_shut_r, to_shut_nxt;
  logic wd_fault, park_evt;
  assign wd_fault = |(wd_err_r & wd_en);
  assign park_evt = ~s_req | s_brown | ~pg | |s_err | sw_park | sw_cycle | wd_fault | ~s_mreq;

  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt = tmr_r + 16'h0001;
    to_off_nxt = to_off_r;
    to_shut_nxt = to_shut_r;
    unique case (state_r)
      ST_OFF:
      begin
        tmr_nxt = 16'h0000;
        if (s_req && !s_brown && !(|s_warn))  // [R2] [R15]
          state_nxt = ST_RAILS;
      end
      ST_RAILS:
      begin
        tmr_nxt = 16'h0000;
        if (!s_req || s_brown)
          state_nxt = ST_OFF;
        else if (pg)
          state_nxt = ST_HOST_RST;
      end
      ST_HOST_RST:
        if (!pg || !s_req || s_brown)
          state_nxt = ST_OFF;
        else if (tmr_r == 16'(HOST_RST_CYC - 1))
          state_nxt = ST_STANDBY;
      ST_STANDBY:
      begin
        tmr_nxt = 16'h0000;
        if (|s_err)
          state_nxt = ST_SHUTDOWN;  // [R14]
        else if (!s_req || s_brown || !pg || sw_cycle || wd_fault)  // [R24]
          state_nxt = ST_OFF;
        else if (s_mreq)
          state_nxt = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        tmr_nxt = 16'h0000;
        to_off_nxt = ~s_req | s_brown | ~pg | sw_cycle | wd_fault;  // [R3] [R24]
        to_shut_nxt = |s_err;  // [R14]
        if (park_evt)
          state_nxt = ST_PARKING;
      end
      ST_PARKING:
        if (tmr_r == 16'(PARK_CYC - 1))
          state_nxt = to_shut_r ? ST_SHUTDOWN : (to_off_r ? ST_OFF : ST_STANDBY);  // [R3]
      ST_SHUTDOWN:
      begin
        tmr_nxt = 16'h0000;
        if (!s_req)
          state_nxt = ST_OFF;  // [R25]
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)  // [R1]
    begin
      state_r <= ST_OFF;
      tmr_r <= 16'h0000;
      to_off_r <= 1'b0;
      to_shut_r <= 1'b0;
      tick_cnt_r <= 6'd0;
      wd_cnt_r <= '{16'h0000, 16'h0000};
      wd_arm_r <= 2'b00;
      wd_err_r <= 2'b00;
      win_r <= 16'h0000;
      edge_r <= 16'h0000;
      ratio_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      to_off_r <= to_off_nxt;
      to_shut_r <= to_shut_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      wd_arm_r <= wd_arm_nxt;
      wd_err_r <= wd_err_nxt;
      win_r <= win_nxt;
      edge_r <= edge_nxt;
      ratio_r <= ratio_nxt;
    end
  end

  // Outputs decoded from registered state
  assign rail_enable_o = state_r != ST_OFF && state_r != ST_SHUTDOWN;
  assign host_reset_n_o = state_r == ST_STANDBY || state_r == ST_ACTIVE || state_r == ST_PARKING;
  assign park_n_o = state_r != ST_PARKING;
  assign mirror_supply_en_o = state_r == ST_ACTIVE;
  assign rail_monitor_aggregate_good_o = pg;  // [R4]
  assign state_o = state_r;
  assign watchdog_error_o = wd_err_r;
  assign temp_warn_irq_o = ctrl_r[CTRL_WARN_IRQ_EN] & |s_warn;  // [R13]
endmodule

`default_nettype wire

/* File: logic/ssm_pkg.sv */
// Constants, states and carriers of the system supervisor block.
// Assumes one 50 MHz clock drives the whole block.
package ssm_pkg;
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int WD_TICK_US = 1;
  localparam int WD_TICK_CYC = WD_TICK_US * CYC_PER_US;
  localparam int HOST_RST_US = 20;
  localparam int HOST_RST_CYC = HOST_RST_US * CYC_PER_US;
  localparam int PARK_US = 100;
  localparam int PARK_CYC = PARK_US * CYC_PER_US;
  localparam int RATIO_WIN_US = 40;
  localparam int RATIO_WIN_CYC = RATIO_WIN_US * CYC_PER_US;
  // Serial frame
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int FRAME_BITS = CMD_BITS + DATA_BITS;
  // Register indexes
  localparam logic [6:0] REG_STATUS = 7'h00;
  localparam logic [6:0] REG_CTRL = 7'h01;
  localparam logic [6:0] REG_WD1_OPEN = 7'h02;
  localparam logic [6:0] REG_WD1_CLOSE = 7'h03;
  localparam logic [6:0] REG_WD2_OPEN = 7'h04;
  localparam logic [6:0] REG_WD2_CLOSE = 7'h05;
  localparam logic [6:0] REG_RATIO = 7'h06;
  localparam logic [6:0] REG_REV = 7'h07;
  // Status fields
  localparam int STAT_TEMP_LSB = 0;
  localparam int STAT_WDERR_LSB = 4;
  localparam int STAT_PG = 6;
  localparam int STAT_BROWN = 7;
  localparam int STAT_STATE_LSB = 8;
  // Control fields
  localparam int CTRL_WD_EN_LSB = 0;
  localparam int CTRL_SW_PARK = 2;
  localparam int CTRL_SW_CYCLE = 3;
  localparam int CTRL_WARN_IRQ_EN = 4;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] WD_OPEN_RST = 16'h000a;
  localparam logic [15:0] WD_CLOSE_RST = 16'h0064;
  localparam logic [15:0] REV_ID = 16'h0011;  // Arbitrary value

  typedef enum logic [2:0] {
    ST_OFF, ST_RAILS, ST_HOST_RST, ST_STANDBY, ST_ACTIVE, ST_PARKING, ST_SHUTDOWN
  } ssm_state_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } ssm_spi_in_s;
endpackage

/* File: verif/ssm_spi_primary.sv */
// Serial primary model: runs whole 24-bit mode 0 frames on one port.
// Assumes a 160 ns serial clock and a caller that waits for each frame.
`timescale 1ns/10ps
`default_nettype none
module ssm_spi_primary (
  // Serial lines
  input wire logic miso_i,
  output var ssm_pkg::ssm_spi_in_s spi_o
);
  import ssm_pkg::*;
  initial
    spi_o = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};

  task automatic xfer(input logic [7:0] c, input logic [15:0] d, output logic [15:0] r);
    logic [23:0] f;
    f = {c, d};
    r = 16'h0000;
    // Odd offset keeps the serial edges off the system clock edges
    #7;
    spi_o.cs_n = 1'b0;
    #80;
    // Full frame only, mosi changes while the clock is low
    for (int i = 23; i >= 0; i--)
    begin
      spi_o.mosi = f[i];
      #80;
      if (i < 16)
        r = {r[14:0], miso_i};
      spi_o.sclk = 1'b1;
      #80;
      spi_o.sclk = 1'b0;
    end
    #80;
    spi_o.cs_n = 1'b1;
    // Released line must not keep its last value
    spi_o.mosi = ~spi_o.mosi;
    #160;
  endtask
endmodule
`default_nettype wire

/* File: verif/ssm_supervisor_props.sv */
// Port assertions of the system supervisor.
// Assumes pins are seen within three clocks, hence the five-cycle histories.
`timescale 1ns/10ps
`default_nettype none
module ssm_supervisor_props #(
  parameter int PARK_CYC = 20
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Watched inputs
  input wire logic system_power_request_i,
  input wire logic main_input_brownout_sense_i,
  input wire logic [3:0] rail_fault_i,
  input wire logic [1:0] temp_warn_i,
  input wire logic [1:0] temp_err_i,
  input wire ssm_pkg::ssm_spi_in_s [1:0] spi_i,
  // Watched outputs
  input wire logic rail_enable_o,
  input wire logic host_reset_n_o,
  input wire logic park_n_o,
  input wire logic mirror_supply_en_o,
  input wire logic rail_monitor_aggregate_good_o,
  input wire logic [2:0] state_o,
  input wire logic [1:0] watchdog_error_o,
  input wire logic temp_warn_irq_o,
  input wire logic [1:0] spi_miso_oe_o
);
  import ssm_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  reset_clear_a: assert property (disable iff (1'b0)
    reset_i |=> state_o == 3'd0 && !rail_enable_o && !host_reset_n_o) else $error("reset left outputs set");
  good_none_a: assert property ((rail_fault_i == 4'h0) [*5] |-> rail_monitor_aggregate_good_o)
    else $error("good low without fault");
  good_fault_a: assert property ((rail_fault_i != 4'h0) [*5] |-> !rail_monitor_aggregate_good_o)
    else $error("good high with fault");
  req_gate_a: assert property ((!system_power_request_i) [*5] ##0 state_o == 3'd0 |=> state_o == 3'd0)
    else $error("left off without request");
  warn_gate_a: assert property ((temp_warn_i != 2'b00) [*5] ##0 state_o == 3'd0 |=> state_o == 3'd0)
    else $error("left off while warm");
  brown_gate_a: assert property (main_input_brownout_sense_i [*5] ##0 state_o == 3'd0 |=> state_o == 3'd0)
    else $error("left off in brownout");
  shut_hold_a: assert property (system_power_request_i [*5] ##0 state_o == 3'd6 |=> state_o == 3'd6)
    else $error("shutdown left with request high");
  shut_enter_a: assert property ((temp_err_i != 2'b00) [*3] ##0 state_o == 3'd3 |-> ##[1:2] state_o == 3'd6)
    else $error("over temperature not shut down");
  shut_quiet_a: assert property (state_o == 3'd6 |-> !rail_enable_o && !mirror_supply_en_o)
    else $error("supplies on in shutdown");
  park_out_a: assert property (park_n_o == (state_o != 3'd5))
    else $error("park output wrong");
  wd_off_a: assert property ($rose(|watchdog_error_o) && state_o == 3'd3 |-> ##[1:4] state_o == 3'd0)
    else $error("watchdog error kept standby");
  irq_quiet_a: assert property ((temp_warn_i == 2'b00) [*5] |-> !temp_warn_irq_o)
    else $error("irq without warning");
  oe_idle_a: assert property ((spi_i[0].cs_n && spi_i[1].cs_n) [*5] |-> spi_miso_oe_o == 2'b00)
    else $error("miso driven outside frame");
endmodule
bind ssm_supervisor ssm_supervisor_props #(.PARK_CYC(PARK_CYC)) i_ssm_supervisor_props (.*);
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench of the system supervisor with two serial primaries.
// Assumes ssm_spi_primary.sv and the package constants.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ssm_pkg::*;
  logic mclk;
  logic seq;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic brown = 1'b0;
  logic mreq = 1'b0;
  logic [3:0] fault = 4'h0;
  logic [1:0] trig = 2'b00;
  logic [1:0] warn = 2'b00;
  logic [1:0] terr = 2'b00;
  logic [1:0] miso;
  logic [1:0] werr;
  logic [1:0] oe;
  logic ren, hrst_n, park_n, msup, good, irq;
  logic [2:0] st;
  logic [15:0] rd;
  ssm_spi_in_s s0, s1;
  int num_errors = 0;
  int compares = 0;
  // Each row is {rail faults, expected good}
  logic [4:0] rows [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1e};

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    seq = 1'b0;
    forever #17 seq = ~seq;
  end

  ssm_supervisor #(.PARK_CYC(20)) i_ssm_supervisor (
    .mclk_i(mclk), .reset_i(rst), .system_power_request_i(req), .main_input_brownout_sense_i(brown),
    .rail_fault_i(fault), .mirror_power_request_i(mreq), .rail_enable_o(ren), .host_reset_n_o(hrst_n),
    .park_n_o(park_n), .mirror_supply_en_o(msup), .rail_monitor_aggregate_good_o(good), .state_o(st),
    .watchdog_trigger_input_i(trig), .watchdog_error_o(werr), .temp_warn_i(warn), .temp_err_i(terr),
    .temp_warn_irq_o(irq), .external_sequencer_clock_i(seq), .spi_i({s1, s0}), .spi_miso_o(miso),
    .spi_miso_oe_o(oe)
  );
  ssm_spi_primary u_pri (.miso_i(miso[0]), .spi_o(s0));
  ssm_spi_primary u_mon (.miso_i(miso[1]), .spi_o(s1));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic sp(input bit p, input logic [7:0] c, input logic [15:0] d);
    if (p)
      u_mon.xfer(c, d, rd);
    else
      u_pri.xfer(c, d, rd);
    cyc(1);
  endtask
  task automatic wst(input logic [2:0] s, input int lim);
    int k;
    k = 0;
    while (st !== s && k < lim)
    begin
      cyc(1);
      k++;
    end
    chk(16'(st), 16'(s), "state");
  endtask
  task automatic wd(input int k);
    trig[k] = 1'b1;
    cyc(10);
    trig[k] = 1'b0;
    cyc(10);
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #1000000;
    num_errors++;
    test_done;
  end

  initial
  begin
    cyc(3);
    chk(16'({st, ren, hrst_n, park_n, werr}), 16'h0004, "reset");
    rst = 1'b0;
    foreach (rows[i])
    begin
      fault = rows[i][4:1];
      cyc(5);
      chk(16'(good), 16'(rows[i][0]), "rail good");
    end
    fault = 4'h0;
    req = 1'b1;
    warn = 2'b01;
    cyc(20);
    chk(16'(st), 16'h0000, "warm start");
    warn = 2'b00;
    brown = 1'b1;
    cyc(20);
    chk(16'(st), 16'h0000, "brownout start");
    brown = 1'b0;
    wst(ST_STANDBY, 1200);
    chk(16'({hrst_n, ren}), 16'h0003, "standby outputs");
    sp(1, {1'b0, REG_REV}, 16'h0000);
    chk(rd, REV_ID, "monitor read");
    sp(0, {1'b0, REG_WD1_OPEN}, 16'h0000);
    chk(rd, WD_OPEN_RST, "open reset");
    sp(0, {1'b1, REG_CTRL}, 16'h0011);
    sp(1, {1'b1, REG_CTRL}, 16'h0002);
    sp(1, {1'b0, REG_CTRL}, 16'h0000);
    chk(rd, 16'h0011, "monitor write");
    // A read of an odd index on the primary must not write it back
    sp(0, {1'b0, REG_CTRL}, 16'h0000);
    chk(rd, 16'h0011, "primary read");
    fork
      sp(1, {1'b0, REG_RATIO}, 16'h0000);
      begin
        cyc(20);
        chk(16'(oe), 16'h0002, "miso enable");
      end
    join
    chk(16'(oe), 16'h0000, "miso idle");
    // 29.4 MHz seen at 50 MHz aliases to about 824 edges per window
    chk(16'(rd >= 16'h0320 && rd <= 16'h0352), 16'h0001, "ratio");
    warn = 2'b10;
    cyc(5);
    chk(16'(irq), 16'h0001, "warn irq");
    sp(1, {1'b0, REG_STATUS}, 16'h0000);
    chk(16'(rd[10:0]), 16'h0342, "status");
    warn = 2'b00;
    // Disabled second watchdog sees a burst, first one an early edge
    wd(1);
    wd(1);
    wd(0);
    cyc(100);
    wd(0);
    chk(16'(werr), 16'h0001, "early edge");
    chk(16'(hrst_n), 16'h0000, "watchdog restart");
    sp(0, {1'b1, REG_CTRL}, 16'h0000);
    chk(16'(werr), 16'h0000, "disabled clears");
    sp(0, {1'b1, REG_CTRL}, 16'h0001);
    wst(ST_STANDBY, 1200);
    wd(0);
    cyc(580);
    wd(0);
    cyc(580);
    wd(0);
    chk(16'(werr), 16'h0000, "in window");
    cyc(5100);
    chk(16'(werr), 16'h0001, "window closed");
    sp(0, {1'b1, REG_CTRL}, 16'h0000);
    wst(ST_STANDBY, 1200);
    terr = 2'b10;
    wst(ST_SHUTDOWN, 10);
    terr = 2'b00;
    cyc(20);
    chk(16'({st, ren}), 16'h000c, "shutdown held");
    req = 1'b0;
    wst(ST_OFF, 10);
    req = 1'b1;
    wst(ST_STANDBY, 1200);
    mreq = 1'b1;
    wst(ST_ACTIVE, 10);
    chk(16'(msup), 16'h0001, "mirror on");
    brown = 1'b1;
    wst(ST_PARKING, 10);
    chk(16'(park_n), 16'h0000, "parking");
    wst(ST_OFF, 40);
    test_done;
  end
endmodule
`default_nettype wire
